// *** src/ffps_pkg.sv ***
package ffps_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_KHZ   = 40000;
  localparam int RECOV_MS  = 100;
  localparam int BOCP_MS   = 110;
  localparam int RECOV_CYC = RECOV_MS * CLK_KHZ;
  localparam int BOCP_CYC  = BOCP_MS * CLK_KHZ;
  localparam int TMR_W     = 23;
  // ----------------------------------------
  // status and mask bit positions
  // ----------------------------------------
  localparam int NEVT = 14;
  localparam int INPUT_UNDERVOLTAGE_FLAG       = 0;
  localparam int INPUT_OVERVOLTAGE_FLAG        = 1;
  localparam int SUPPLY_UNDERVOLTAGE_FLAG      = 2;
  localparam int INPUT_OVERCURRENT_FLAG        = 3;
  localparam int CHARGE_PUMP_FAULT_FLAG        = 4;
  localparam int CHARGE_PUMP_PARTS_MISSING_FLAG = 5;
  localparam int SYNC_CLOCK_INVALID_FLAG       = 6;
  localparam int CONFIG_INTEGRITY_ERROR_FLAG   = 7;
  localparam int OUTPUT_OVERVOLTAGE_LOW_FLAG   = 8;
  localparam int OUTPUT_OVERVOLTAGE_HIGH_FLAG  = 9;
  localparam int BOOST_OVERCURRENT_FLAG        = 10;
  localparam int STRING_CONFIG_DETECT_FLAG     = 11;
  localparam int MODE_SELECT_DETECT_FLAG       = 12;
  localparam int FREQUENCY_SELECT_DETECT_FLAG  = 13;
  localparam logic [13:0] IRQ_CAPABLE = 14'h06ff;
  localparam logic [13:0] MASK_RST    = 14'h3fff;
  // ----------------------------------------
  // register map and defaults
  // ----------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_CFG    = 8'h08;
  localparam logic [7:0] REG_DEFS   = 8'h0c;
  localparam logic [6:0] I2C_ADDR_DEF = 7'h2a;
  localparam logic [6:0] I2C_ADDR_ALT = 7'h2b;
  localparam logic [15:0] BOOST_DEF_KHZ = 16'h0190;
  localparam logic [15:0] PWM_DEF_HZ    = 16'h0131;
  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_STBY  = 2'b01,
    ST_RUN   = 2'b10,
    ST_RECOV = 2'b11
  } ffps_state_t;
endpackage

// *** src/ffps_evt_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface ffps_evt_if #(parameter int N = 14);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] mask;
  logic [N-1:0] status;
  logic         irq;
  modport src (output set, output clr, output mask, input status, input irq);
  modport flg (input set, input clr, input mask, output status, output irq);
endinterface
`default_nettype wire

// *** src/ffps_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module ffps_timer
  import ffps_pkg::*;
#(
  parameter int W = TMR_W,
  parameter int N = RECOV_CYC
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic run,
  output var  logic done
);
  logic [W-1:0] cnt_r;

  // done holds while run stays high; any drop restarts the count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else if (cnt_r == W'(N - 1)) begin
      done <= 1'b1;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end
endmodule
`default_nettype wire

// *** src/ffps_flags.sv ***
`timescale 1ns/100ps
`default_nettype none
module ffps_flags
  import ffps_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  ffps_evt_if.flg   ev
);
  logic [NEVT-1:0] status_nxt;

  // set wins over a write-one clear in the same cycle
  always_comb begin
    status_nxt = (ev.status & ~ev.clr) | ev.set;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ev.status <= '0;
    end else begin
      ev.status <= status_nxt;
    end
  end

  // non-interrupting faults never reach the pin, whatever the mask
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ev.irq <= 1'b0;
    end else begin
      ev.irq <= |(status_nxt & ev.mask & IRQ_CAPABLE);
    end
  end
endmodule
`default_nettype wire

// *** src/ffps_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module ffps_top
  import ffps_pkg::*;
#(
  parameter int RECOV_CYCLES = RECOV_CYC,
  parameter int BOCP_CYCLES  = BOCP_CYC
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  input  wire logic        init_done,
  input  wire logic        enable,
  input  wire logic        bright_nz,
  input  wire logic        in_uv_trip,
  input  wire logic        in_ov_trip,
  input  wire logic        vdd_uv_trip,
  input  wire logic        in_oc_trip,
  input  wire logic        cp_abnormal,
  input  wire logic        cp_parts_missing,
  input  wire logic        sync_clk_valid,
  input  wire logic        boost_sync_input,
  input  wire logic        crc_fail,
  input  wire logic        fb_ovl_trip,
  input  wire logic        fb_ovh_trip,
  input  wire logic        dis_ov_trip,
  input  wire logic        fb_below_uvp,
  input  wire logic        string_res_bad,
  input  wire logic        mode_res_bad,
  input  wire logic        mode_addr_sel,
  input  wire logic        boost_fset_bad,
  input  wire logic        dimming_frequency_resistor_bad,
  output var  logic        irq,
  output var  logic        plfet_en,
  output var  logic        boost_en,
  output var  logic        boost_sw_en,
  output var  logic        led_drv_en,
  output var  logic        cp_en,
  output var  logic        use_ext_sync,
  output var  logic        spread_en,
  output var  logic        string_cfg_default,
  output var  logic        phase_shift_default,
  output var  logic [6:0]  i2c_addr,
  output var  logic        boost_freq_default,
  output var  logic        pwm_freq_default
);
  ffps_evt_if #(.N(NEVT)) ev ();

  ffps_state_t     state_r;
  ffps_state_t     state_nxt;
  logic [NEVT-1:0] mask_r;
  logic [NEVT-1:0] evt;
  logic            hold_fault;
  logic            recov_cause;
  logic            ovh_any;
  logic            init_cap;
  logic            recov_done;
  logic            bocp_done;
  logic            sync_armed_r;
  logic            fallback_r;
  logic            sync_fail;
  logic            cp_off_r;

  // ----------------------------------------
  // timers
  // ----------------------------------------
  ffps_timer #(.W(TMR_W), .N(RECOV_CYCLES)) u_recov (
    .clock  (clock),
    .resetn (resetn),
    .run    (state_r == ST_RECOV),
    .done   (recov_done)
  );

  // overcurrent only once feedback stays low for the whole window
  ffps_timer #(.W(TMR_W), .N(BOCP_CYCLES)) u_bocp (
    .clock  (clock),
    .resetn (resetn),
    .run    (state_r == ST_RUN && fb_below_uvp),
    .done   (bocp_done)
  );

  ffps_flags u_flags (
    .clock  (clock),
    .resetn (resetn),
    .ev     (ev)
  );

  // ----------------------------------------
  // fault classification
  // ----------------------------------------
  assign ovh_any     = fb_ovh_trip | dis_ov_trip;
  assign init_cap    = (state_r == ST_INIT) && init_done;
  assign sync_fail   = sync_armed_r && !sync_clk_valid;
  assign hold_fault  = in_uv_trip | in_ov_trip | vdd_uv_trip;
  assign recov_cause = in_oc_trip | cp_abnormal | ovh_any | bocp_done;

  always_comb begin
    evt = '0;
    evt[INPUT_UNDERVOLTAGE_FLAG]        = in_uv_trip;
    evt[INPUT_OVERVOLTAGE_FLAG]         = in_ov_trip;
    evt[SUPPLY_UNDERVOLTAGE_FLAG]       = vdd_uv_trip;
    evt[INPUT_OVERCURRENT_FLAG]         = in_oc_trip;
    evt[CHARGE_PUMP_FAULT_FLAG]         = cp_abnormal | cp_parts_missing;
    evt[CHARGE_PUMP_PARTS_MISSING_FLAG] = cp_parts_missing;
    evt[SYNC_CLOCK_INVALID_FLAG]        = sync_fail;
    evt[CONFIG_INTEGRITY_ERROR_FLAG]    = crc_fail;
    evt[OUTPUT_OVERVOLTAGE_LOW_FLAG]    = fb_ovl_trip;
    evt[OUTPUT_OVERVOLTAGE_HIGH_FLAG]   = ovh_any;
    evt[BOOST_OVERCURRENT_FLAG]         = bocp_done;
    evt[STRING_CONFIG_DETECT_FLAG]      = init_cap && string_res_bad;
    evt[MODE_SELECT_DETECT_FLAG]        = init_cap && mode_res_bad;
    evt[FREQUENCY_SELECT_DETECT_FLAG]   = init_cap && (boost_fset_bad || dimming_frequency_resistor_bad);
  end

  assign ev.set  = evt;
  assign ev.mask = mask_r;
  assign ev.clr  = (wr && addr == REG_STATUS) ? wdata[NEVT-1:0] : '0;
  assign irq     = ev.irq;

  // ----------------------------------------
  // operating state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_INIT: begin
        if (init_done) begin
          state_nxt = ST_STBY;
        end
      end
      ST_STBY: begin
        if (enable && !hold_fault && !recov_cause) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable || hold_fault) begin
          state_nxt = ST_STBY;
        end else if (recov_cause) begin
          state_nxt = ST_RECOV;
        end
      end
      ST_RECOV: begin
        // output overvoltage must fall before the retry is allowed
        if (!enable) begin
          state_nxt = ST_STBY;
        end else if (recov_done && !ovh_any && bright_nz) begin
          state_nxt = ST_STBY;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // power stage enables follow the next state so they drop with it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      plfet_en    <= 1'b0;
      boost_en    <= 1'b0;
      boost_sw_en <= 1'b0;
      led_drv_en  <= 1'b0;
    end else begin
      plfet_en    <= state_nxt == ST_RUN;
      boost_en    <= state_nxt == ST_RUN;
      boost_sw_en <= state_nxt == ST_RUN && !fb_ovl_trip;
      led_drv_en  <= state_nxt == ST_RUN && bright_nz;
    end
  end

  // ----------------------------------------
  // charge pump
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cp_off_r <= 1'b0;
      cp_en    <= 1'b0;
    end else begin
      cp_off_r <= cp_off_r | cp_parts_missing;
      cp_en    <= !(cp_off_r || cp_parts_missing) && state_r != ST_INIT;
    end
  end

  // ----------------------------------------
  // sync clock fallback
  // ----------------------------------------
  // armed only when enabled with a good clock; a clock that
  // never showed up is not a fault
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_armed_r <= 1'b0;
      fallback_r   <= 1'b0;
    end else if (!enable) begin
      sync_armed_r <= 1'b0;
      fallback_r   <= 1'b0;
    end else if (sync_fail) begin
      sync_armed_r <= 1'b0;
      fallback_r   <= 1'b1;
    end else if (state_r == ST_STBY && sync_clk_valid && !fallback_r) begin
      sync_armed_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      use_ext_sync <= 1'b0;
      spread_en    <= 1'b0;
    end else begin
      use_ext_sync <= sync_armed_r && sync_clk_valid;
      spread_en    <= fallback_r && boost_sync_input;
    end
  end

  // ----------------------------------------
  // resistor defaults, caught once at init
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      string_cfg_default  <= 1'b0;
      phase_shift_default <= 1'b0;
      i2c_addr            <= I2C_ADDR_DEF;
      boost_freq_default  <= 1'b0;
      pwm_freq_default    <= 1'b0;
    end else if (init_cap) begin
      string_cfg_default  <= string_res_bad;
      phase_shift_default <= mode_res_bad;
      i2c_addr            <= (mode_res_bad || !mode_addr_sel) ? I2C_ADDR_DEF
                                                              : I2C_ADDR_ALT;
      boost_freq_default  <= boost_fset_bad;
      pwm_freq_default    <= dimming_frequency_resistor_bad;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_r <= MASK_RST;
    end else if (wr && addr == REG_MASK) begin
      mask_r <= wdata[NEVT-1:0];
    end
  end

  // unmapped reads and idle cycles return zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (!rd) begin
      rdata <= '0;
    end else begin
      unique case (addr)
        REG_STATUS: rdata <= {18'h0, ev.status};
        REG_MASK:   rdata <= {18'h0, mask_r};
        REG_CFG:    rdata <= {16'h0, 1'b0, i2c_addr, spread_en, use_ext_sync,
                              pwm_freq_default, boost_freq_default,
                              phase_shift_default, string_cfg_default,
                              state_r};
        REG_DEFS:   rdata <= {BOOST_DEF_KHZ, PWM_DEF_HZ};
        default:    rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_uv_stby;
    state_r == ST_RUN && in_uv_trip |=> state_r == ST_STBY && !plfet_en;
  endproperty
  a_uv_stby: assert property (p_uv_stby) else $error("uv not to standby");

  property p_ov_hold;
    state_r == ST_STBY && in_ov_trip |=> state_r == ST_STBY;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("restart under ov");

  property p_vdd_norecov;
    state_r == ST_RUN && vdd_uv_trip |=> state_r == ST_STBY;
  endproperty
  a_vdd_norecov: assert property (p_vdd_norecov) else $error("vdd uv path");

  property p_oc_recov;
    state_r == ST_RUN && enable && !hold_fault && in_oc_trip
      |=> state_r == ST_RECOV ##1 !plfet_en [*4];
  endproperty
  a_oc_recov: assert property (p_oc_recov) else $error("oc not recovered");

  property p_cp_parts;
    cp_parts_missing |=> !cp_en && ev.status[CHARGE_PUMP_FAULT_FLAG];
  endproperty
  a_cp_parts: assert property (p_cp_parts) else $error("pump not off");

  property p_sync_fall;
    sync_armed_r && !sync_clk_valid && enable |=> fallback_r ##1 !use_ext_sync;
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("no sync fallback");

  property p_spread;
    fallback_r |=> spread_en == $past(boost_sync_input);
  endproperty
  a_spread: assert property (p_spread) else $error("spread mismatch");

  property p_crc;
    crc_fail |=> ev.status[CONFIG_INTEGRITY_ERROR_FLAG];
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag missing");

  property p_ovpl;
    fb_ovl_trip |=> !boost_sw_en;
  endproperty
  a_ovpl: assert property (p_ovpl) else $error("switching under ovp low");

  property p_ovh_wait;
    state_r == ST_RECOV && enable && ovh_any |=> state_r == ST_RECOV;
  endproperty
  a_ovh_wait: assert property (p_ovh_wait) else $error("left recovery early");

  property p_recov_min;
    $rose(state_r == ST_RECOV) |-> (state_r == ST_RECOV || !enable) [*8];
  endproperty
  a_recov_min: assert property (p_recov_min) else $error("recovery too short");

  property p_mode_def;
    init_cap && mode_res_bad |=> i2c_addr == I2C_ADDR_DEF && phase_shift_default;
  endproperty
  a_mode_def: assert property (p_mode_def) else $error("mode default wrong");

  property p_stby_go;
    state_r == ST_STBY && enable && !hold_fault && !recov_cause |=> state_r == ST_RUN;
  endproperty
  a_stby_go: assert property (p_stby_go) else $error("standby stalled");

  property p_sticky;
    ev.status[INPUT_OVERCURRENT_FLAG] && !ev.clr[INPUT_OVERCURRENT_FLAG]
      |=> ev.status[INPUT_OVERCURRENT_FLAG];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  c_recov: cover property (state_r == ST_RECOV ##1 state_r == ST_STBY);
  c_run:   cover property (state_r == ST_STBY ##1 state_r == ST_RUN);
  c_sync:  cover property ($rose(fallback_r));
  c_irq:   cover property ($rose(irq));
endmodule
`default_nettype wire

// *** verif/ffps_afe_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// analog front end: comparators and sync detector
// ----------------------------------------
// req order: in_uv, in_ov, vdd_uv, in_oc, cp_abnormal, cp_parts,
// crc, fb_ovl, fb_ovh, dis_ov, fb_below_uvp
module ffps_afe_model (
  input  wire logic        clock,
  input  wire logic [10:0] req,
  input  wire logic        sync_run,
  output var  logic [10:0] trip,
  output var  logic        sync_valid
);
  // one cycle of comparator deglitch, so no trip lands on the bench's own edge
  initial begin
    trip = 11'h000;
    sync_valid = 1'b0;
  end
  always @(posedge clock) begin
    trip <= req;
    sync_valid <= sync_run;
  end
endmodule
`default_nettype wire

// *** verif/ffps_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module ffps_bench;
  import ffps_pkg::*;
  localparam int RC = 16;
  localparam int BC = 20;
  logic        clock, resetn, wr, rd, init_done, enable, bright_nz, sync_run, bsync;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [10:0] req;
  logic [3:0]  rbad;
  logic        asel;
  wire logic [31:0] rdata;
  wire logic [10:0] trip;
  wire logic        sval, irq, plfet_en, boost_en, boost_sw_en, led_drv_en, cp_en;
  wire logic        use_ext_sync, spread_en, sdef, pdef, bdef, fdef;
  wire logic [6:0]  i2c_addr;
  int n_mismatch = 0;
  int checked = 0;
  // ----------------------------------------
  // clock, reset, instances
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ffps_afe_model i_afe (.clock(clock), .req(req), .sync_run(sync_run), .trip(trip),
    .sync_valid(sval));
  ffps_top #(.RECOV_CYCLES(RC), .BOCP_CYCLES(BC)) i_dut (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .init_done(init_done), .enable(enable), .bright_nz(bright_nz),
    .in_uv_trip(trip[0]), .in_ov_trip(trip[1]), .vdd_uv_trip(trip[2]),
    .in_oc_trip(trip[3]), .cp_abnormal(trip[4]), .cp_parts_missing(trip[5]),
    .sync_clk_valid(sval), .boost_sync_input(bsync), .crc_fail(trip[6]),
    .fb_ovl_trip(trip[7]), .fb_ovh_trip(trip[8]), .dis_ov_trip(trip[9]),
    .fb_below_uvp(trip[10]), .string_res_bad(rbad[3]), .mode_res_bad(rbad[2]),
    .mode_addr_sel(asel), .boost_fset_bad(rbad[1]), .dimming_frequency_resistor_bad(rbad[0]), .irq(irq),
    .plfet_en(plfet_en), .boost_en(boost_en), .boost_sw_en(boost_sw_en),
    .led_drv_en(led_drv_en), .cp_en(cp_en), .use_ext_sync(use_ext_sync),
    .spread_en(spread_en), .string_cfg_default(sdef), .phase_shift_default(pdef),
    .i2c_addr(i2c_addr), .boost_freq_default(bdef), .pwm_freq_default(fdef));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask
  // bounded wait; the design may take a few edges through standby
  task automatic wait_pl(input logic exp);
    int k;
    k = 0;
    while (plfet_en !== exp && k < 60) begin
      tick(1);
      k++;
    end
    chk("plfet_en", exp, plfet_en);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init;
    chk("i2c_addr rst", 7'h2a, i2c_addr);
    chk("plfet rst", 0, plfet_en);
    @(posedge clock);
    init_done <= 1'b1;
    tick(3);
    rreg(REG_MASK, 32'h00003fff, "mask");
    rreg(8'h10, 32'h0, "unmapped");
    rreg(REG_STATUS, 32'h00003800, "status init");
    rreg(REG_DEFS, 32'h01900131, "defaults reg");
    chk("irq none", 0, irq);
    chk("defaults", 4'hf, {sdef, pdef, bdef, fdef});
    chk("i2c_addr", 7'h2a, i2c_addr);
    wreg(REG_STATUS, 32'h3fff);
    rreg(REG_STATUS, 32'h0, "status clr");
    wait_pl(1);
    chk("run outs", 4'hf, {boost_en, boost_sw_en, led_drv_en, cp_en});
  endtask
  task automatic t_evt(input int idx, input logic [13:0] bits, input logic irqx,
                       input logic runx, input int hold, input int gap);
    @(posedge clock);
    req <= req | (11'h001 << idx);
    tick(hold);
    chk("plfet_en", runx, plfet_en);
    chk("boost_en", runx, boost_en);
    chk("led_drv_en", runx, led_drv_en);
    chk("boost_sw_en", runx && idx != 7, boost_sw_en);
    chk("irq", irqx, irq);
    @(posedge clock);
    req <= req & ~(11'h001 << idx);
    if (gap > 0) begin
      tick(gap);
      chk("plfet held", runx, plfet_en);
    end
    rreg(REG_STATUS, {18'h0, bits}, "status");
    wreg(REG_STATUS, 32'h3fff);
    rreg(REG_STATUS, 32'h0, "status clr");
    chk("irq clr", 0, irq);
    wait_pl(1);
  endtask
  task automatic t_mask;
    wreg(REG_MASK, 32'h0);
    @(posedge clock);
    req[6] <= 1'b1;
    tick(4);
    chk("irq masked", 0, irq);
    wreg(REG_MASK, 32'h80);
    tick(2);
    chk("irq unmasked", 1, irq);
    @(posedge clock);
    req[6] <= 1'b0;
    wreg(REG_STATUS, 32'h80);
    tick(2);
    chk("irq cleared", 0, irq);
    wreg(REG_MASK, 32'h3fff);
  endtask
  task automatic t_bocp;
    @(posedge clock);
    req[10] <= 1'b1;
    tick(BC - 6);
    @(posedge clock);
    req[10] <= 1'b0;
    tick(3);
    chk("short dip", 1, plfet_en);
    rreg(REG_STATUS, 32'h0, "status dip");
    t_evt(10, 14'h0400, 1, 0, BC + 6, 4);
  endtask
  task automatic t_sync;
    @(posedge clock);
    enable <= 1'b0;
    sync_run <= 1'b1;
    tick(4);
    @(posedge clock);
    enable <= 1'b1;
    wait_pl(1);
    tick(2);
    chk("ext sync", 1, use_ext_sync);
    @(posedge clock);
    sync_run <= 1'b0;
    bsync <= 1'b1;
    tick(4);
    chk("ext sync lost", 0, use_ext_sync);
    chk("spread hi", 1, spread_en);
    chk("irq sync", 1, irq);
    chk("still running", 1, plfet_en);
    @(posedge clock);
    bsync <= 1'b0;
    tick(2);
    chk("spread lo", 0, spread_en);
    rreg(REG_STATUS, 32'h40, "status sync");
    wreg(REG_STATUS, 32'h40);
  endtask
  // retry must wait for brightness even after the timer has run out
  task automatic t_bright;
    @(posedge clock);
    bright_nz <= 1'b0;
    req[3] <= 1'b1;
    tick(1);
    chk("led dark", 0, led_drv_en);
    @(posedge clock);
    req[3] <= 1'b0;
    tick(RC + 12);
    chk("dark hold", 0, plfet_en);
    @(posedge clock);
    bright_nz <= 1'b1;
    wait_pl(1);
    rreg(REG_STATUS, 32'h8, "status dark");
    wreg(REG_STATUS, 32'h8);
  endtask
  // second power-up with good string and mode resistors, one bad frequency resistor
  task automatic t_reinit;
    @(posedge clock);
    resetn <= 1'b0;
    rbad <= 4'h2;
    tick(2);
    chk("plfet in rst", 0, plfet_en);
    chk("i2c_addr in rst", 7'h2a, i2c_addr);
    @(posedge clock);
    resetn <= 1'b1;
    tick(2);
    rreg(REG_STATUS, 32'h00002000, "status reinit");
    chk("defaults reinit", 4'h2, {sdef, pdef, bdef, fdef});
    chk("i2c_addr sel", 7'h2b, i2c_addr);
    chk("irq reinit", 0, irq);
    wait_pl(1);
    chk("cp_en reinit", 1, cp_en);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    {wr, rd, init_done, sync_run, bsync} = 5'h00;
    {enable, bright_nz} = 2'h3;
    addr = 8'h00;
    wdata = 32'h0;
    req = 11'h000;
    rbad = 4'hf;
    asel = 1'b1;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    tick(1);
    t_init;
    t_evt(0, 14'h0001, 1, 0, 30, 0);
    t_evt(1, 14'h0002, 1, 0, 30, 0);
    t_evt(2, 14'h0004, 1, 0, 30, 0);
    t_evt(3, 14'h0008, 1, 0, 4, 6);
    t_evt(4, 14'h0010, 1, 0, 4, 6);
    t_evt(8, 14'h0200, 1, 0, 30, 0);
    t_evt(9, 14'h0200, 1, 0, 4, 6);
    t_evt(6, 14'h0080, 1, 1, 4, 0);
    t_evt(7, 14'h0100, 0, 1, 4, 0);
    t_bright;
    t_mask;
    t_bocp;
    t_sync;
    t_evt(5, 14'h0030, 1, 1, 4, 0);
    chk("cp_en off", 0, cp_en);
    t_reinit;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
